// ===== src/alz_pkg.sv
// Constants and types shared by the ambient light zone engine files.
package alz_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SAMPLE_RATE_HZ = 16000;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int unsigned SAMPLE_CNT_W = $clog2(SAMPLE_CYCLES);
  localparam int unsigned RAMP_STEP_US = 1000;
  localparam int unsigned RAMP_STEP_CYCLES = (CLK_HZ / 1000000) * RAMP_STEP_US;

  localparam int unsigned LEVEL_W = 8;
  localparam int unsigned BRIGHT_W = 7;
  localparam int unsigned ZONE_W = 3;
  localparam int unsigned NUM_BOUND = 4;
  localparam int unsigned NUM_ZONE = 5;
  localparam int unsigned AVG_SEL_W = 3;
  localparam int unsigned AVG_BASE_SHIFT = 9;
  localparam int unsigned AVG_MAX_SHIFT = AVG_BASE_SHIFT + 7;
  localparam int unsigned ACC_W = LEVEL_W + AVG_MAX_SHIFT;
  localparam int unsigned LOAD_W = 5;

  localparam logic [7:0] ADDR_GPO_CTRL = 8'h52;
  localparam logic [7:0] ADDR_CONFIG = 8'h60;
  localparam logic [7:0] ADDR_LOAD_RES = 8'h61;
  localparam logic [7:0] ADDR_BOUND0 = 8'h62;
  localparam logic [7:0] ADDR_TARGET0 = 8'h66;
  localparam logic [7:0] ADDR_TRIP = 8'h6b;
  localparam logic [7:0] ADDR_DESCENT = 8'h6c;
  localparam logic [7:0] ADDR_STATUS = 8'h6d;
  localparam logic [7:0] ADDR_LEVEL = 8'h6e;

  localparam int unsigned GPO_ONE_BIT = 0;
  localparam int unsigned GPO_TWO_BIT = 1;
  localparam int unsigned CFG_ENABLE_BIT = 0;
  localparam int unsigned CFG_AUTOGAIN_BIT = 1;
  localparam int unsigned CFG_AVG_LSB = 2;
  localparam int unsigned STAT_LOW_GAIN_BIT = 3;
  localparam int unsigned STAT_IRQ_BIT = 4;
  localparam int unsigned STAT_RAMP_BIT = 5;

  localparam logic [7:0] RST_GPO = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [4:0] RST_LOAD_RES = 5'h00;
  localparam logic [7:0] RST_BOUND = 8'h00;
  localparam logic [6:0] RST_TARGET = 7'h00;
  localparam logic [7:0] RST_TRIP = 8'h00;
  localparam logic [7:0] RST_DESCENT = 8'h00;

  localparam logic [2:0] ZONE_GAIN_UP = 3'h3;
  localparam logic [2:0] ZONE_LOW_FLOOR = 3'h2;
  localparam logic [2:0] ZONE_TOP = 3'h4;

  typedef enum logic [1:0] {
    ALZ_GAIN_HIGH = 2'h1,
    ALZ_GAIN_LOW = 2'h2
  } alz_gain_e;
endpackage

// ===== src/alz_ramp_if.sv
// Link between the zone engine and its brightness ramp.
`timescale 1ns/1ps
`default_nettype none
interface alz_ramp_if;
  import alz_pkg::*;
  logic [BRIGHT_W-1:0] target;
  logic step;
  logic [BRIGHT_W-1:0] level;
  logic busy;
  modport engine (output target, output step, input level, input busy);
  modport ramp (input target, input step, output level, output busy);
endinterface
`default_nettype wire

// ===== src/alz_ramp.sv
// Brightness ramp that moves the LED level one code per step toward its target.
`timescale 1ns/1ps
`default_nettype none
module alz_ramp
  import alz_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  alz_ramp_if.ramp rp
);
  typedef struct packed {
    logic [BRIGHT_W-1:0] level;
    logic busy;
  } alz_ramp_s;

  alz_ramp_s s_q;
  alz_ramp_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (rp.step)
    begin
      if (s_q.level < rp.target)
      begin
        s_d.level = s_q.level + BRIGHT_W'(1);
      end
      else if (s_q.level > rp.target)
      begin
        s_d.level = s_q.level - BRIGHT_W'(1);
      end
    end
    s_d.busy = (s_d.level != rp.target);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign rp.level = s_q.level;
  assign rp.busy = s_q.busy;
endmodule
`default_nettype wire

// ===== src/alz_engine.sv
// Ambient light zone engine: sampling, averaging, zone discrimination, auto-gain.
//
// Operation
// RQ1: Four programmable light boundaries split the level into zones zero to four.
// RQ2: The processed level is compared against each 8-bit boundary.
// RQ3: On a zone change the LED level ramps stepwise to that zone's 7-bit target.
// RQ4: The converter is started at a fixed rate of sixteen thousand per second.
// RQ5: Samples average over one of eight periods; each period end feeds the discriminator.
// RQ6: The discriminator filters transients; steady changes act within two periods; the code can take up to three periods, four across a gain restore.
// RQ7: A zone change pulls the open-drain interrupt pin low.
// RQ8: A 5-bit load select picks the sense resistor; zero leaves the input open.
// RQ9: Without auto-gain both general outputs follow their own control bits.
// RQ10: Auto-gain shows low gain as one low, two high; high gain the reverse.
// RQ11: In high gain a move from zone two to three selects low gain.
// RQ12: In low gain a level below the restore trip returns to high gain.
// RQ13: In low gain the three-to-two descent uses its own boundary register.
// RQ14: Enabling auto-gain starts the sensor in high gain.
// RQ15: With auto-gain, zone zero and zone four never follow each other directly; the code can pass from zone four to zero after a gain restore.
// RQ16: The zone is the count of boundaries that the level exceeds.
`timescale 1ns/1ps
`default_nettype none
module alz_engine
  import alz_pkg::*;
#(
  parameter int unsigned RAMP_CYCLES = RAMP_STEP_CYCLES
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic adc_start,
  input wire logic adc_valid,
  input wire logic [LEVEL_W-1:0] adc_data,
  output logic [LOAD_W-1:0] load_select,
  output logic load_open,
  output logic general_output_one,
  output logic general_output_two,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic [BRIGHT_W-1:0] led_level
);
  localparam int unsigned RAMP_CNT_W = $clog2(RAMP_CYCLES + 1);

  typedef struct packed {
    logic [7:0] gpo_ctrl;
    logic [7:0] config_reg;
    logic [LOAD_W-1:0] load_res;
    logic [NUM_BOUND-1:0][LEVEL_W-1:0] bound;
    logic [NUM_ZONE-1:0][BRIGHT_W-1:0] target;
    logic [LEVEL_W-1:0] gain_restore_trip;
    logic [LEVEL_W-1:0] low_gain_descent_boundary;
    logic [SAMPLE_CNT_W-1:0] sample_cnt;
    logic [ACC_W-1:0] acc;
    logic [AVG_MAX_SHIFT-1:0] avg_cnt;
    logic [LEVEL_W-1:0] level;
    logic [ZONE_W-1:0] cand;
    logic [ZONE_W-1:0] zone;
    alz_gain_e gain;
    logic autogain_prev;
    logic irq_pending;
    logic [RAMP_CNT_W-1:0] ramp_cnt;
    logic ramp_step;
    logic adc_start;
    logic [7:0] rdata;
    logic out_one;
    logic out_two;
    logic load_open;
  } alz_state_s;

  alz_state_s s_q;
  alz_state_s s_d;

  alz_ramp_if rif ();

  // RQ16: count exceeded boundaries
  function automatic logic [ZONE_W-1:0] zone_count(
    input logic [LEVEL_W-1:0] lvl,
    input logic [NUM_BOUND-1:0][LEVEL_W-1:0] bnd
  );
    logic [ZONE_W-1:0] z;
    z = '0;
    for (int i = 0; i < NUM_BOUND; i++)
    begin
      if (lvl > bnd[i])
      begin
        z = z + ZONE_W'(1);
      end
    end
    return z;
  endfunction

  function automatic logic [AVG_MAX_SHIFT-1:0] avg_last(input logic [AVG_SEL_W-1:0] sel);
    logic [AVG_MAX_SHIFT:0] one_hot;
    one_hot = (AVG_MAX_SHIFT + 1)'(1) << (AVG_BASE_SHIFT + 32'(sel));
    return AVG_MAX_SHIFT'(one_hot - (AVG_MAX_SHIFT + 1)'(1));
  endfunction

  logic enabled;
  logic autogain;
  logic [AVG_SEL_W-1:0] avg_sel;
  assign enabled = s_q.config_reg[CFG_ENABLE_BIT];
  assign autogain = s_q.config_reg[CFG_AUTOGAIN_BIT];
  assign avg_sel = s_q.config_reg[CFG_AVG_LSB +: AVG_SEL_W];

  always_comb
  begin
    logic [ACC_W-1:0] acc_sum;
    logic [LEVEL_W-1:0] avg;
    logic [ZONE_W-1:0] raw;
    logic judge;
    acc_sum = '0;
    avg = '0;
    raw = '0;
    judge = 1'b0;
    s_d = s_q;
    s_d.adc_start = 1'b0;
    s_d.ramp_step = 1'b0;

    // RQ9: software control writes
    if (reg_wr)
    begin
      if (reg_addr == ADDR_GPO_CTRL)
      begin
        s_d.gpo_ctrl = reg_wdata;
      end
      if (reg_addr == ADDR_CONFIG)
      begin
        s_d.config_reg = reg_wdata;
      end
      // RQ8: load resistor select
      if (reg_addr == ADDR_LOAD_RES)
      begin
        s_d.load_res = reg_wdata[LOAD_W-1:0];
      end
      // RQ1: boundary registers
      for (int i = 0; i < NUM_BOUND; i++)
      begin
        if (reg_addr == ADDR_BOUND0 + 8'(i))
        begin
          s_d.bound[i] = reg_wdata;
        end
      end
      for (int i = 0; i < NUM_ZONE; i++)
      begin
        if (reg_addr == ADDR_TARGET0 + 8'(i))
        begin
          s_d.target[i] = reg_wdata[BRIGHT_W-1:0];
        end
      end
      if (reg_addr == ADDR_TRIP)
      begin
        s_d.gain_restore_trip = reg_wdata;
      end
      if (reg_addr == ADDR_DESCENT)
      begin
        s_d.low_gain_descent_boundary = reg_wdata;
      end
    end

    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_GPO_CTRL: s_d.rdata = s_q.gpo_ctrl;
        ADDR_CONFIG: s_d.rdata = s_q.config_reg;
        ADDR_LOAD_RES: s_d.rdata = 8'(s_q.load_res);
        ADDR_TRIP: s_d.rdata = s_q.gain_restore_trip;
        ADDR_DESCENT: s_d.rdata = s_q.low_gain_descent_boundary;
        ADDR_LEVEL: s_d.rdata = s_q.level;
        ADDR_STATUS:
        begin
          s_d.rdata = 8'(s_q.zone);
          s_d.rdata[STAT_LOW_GAIN_BIT] = (s_q.gain == ALZ_GAIN_LOW);
          s_d.rdata[STAT_IRQ_BIT] = s_q.irq_pending;
          s_d.rdata[STAT_RAMP_BIT] = rif.busy;
          // Reading the status releases the interrupt; a new event below still wins.
          s_d.irq_pending = 1'b0;
        end
        default:
        begin
          for (int i = 0; i < NUM_BOUND; i++)
          begin
            if (reg_addr == ADDR_BOUND0 + 8'(i))
            begin
              s_d.rdata = s_q.bound[i];
            end
          end
          for (int i = 0; i < NUM_ZONE; i++)
          begin
            if (reg_addr == ADDR_TARGET0 + 8'(i))
            begin
              s_d.rdata = 8'(s_q.target[i]);
            end
          end
        end
      endcase
    end

    // RQ4: converter start rate
    if (s_q.sample_cnt == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1))
    begin
      s_d.sample_cnt = '0;
      s_d.adc_start = enabled;
    end
    else
    begin
      s_d.sample_cnt = s_q.sample_cnt + SAMPLE_CNT_W'(1);
    end

    // RQ14: high gain on enable
    s_d.autogain_prev = autogain;
    if (!autogain || !s_q.autogain_prev)
    begin
      s_d.gain = ALZ_GAIN_HIGH;
    end

    // RQ5: averaging period
    if (enabled && adc_valid)
    begin
      acc_sum = s_q.acc + ACC_W'(adc_data);
      if (s_q.avg_cnt == avg_last(avg_sel))
      begin
        avg = LEVEL_W'(acc_sum >> (AVG_BASE_SHIFT + 32'(avg_sel)));
        s_d.level = avg;
        s_d.acc = '0;
        s_d.avg_cnt = '0;
        judge = 1'b1;
      end
      else
      begin
        s_d.acc = acc_sum;
        s_d.avg_cnt = s_q.avg_cnt + AVG_MAX_SHIFT'(1);
      end
    end

    if (judge)
    begin
      // RQ2: compare against boundaries
      raw = zone_count(avg, s_q.bound);
      if (autogain && s_q.autogain_prev && s_q.gain == ALZ_GAIN_LOW)
      begin
        // RQ13: low gain descent boundary
        if (avg > s_q.bound[NUM_BOUND-1])
        begin
          raw = ZONE_TOP;
        end
        else if (avg > s_q.low_gain_descent_boundary)
        begin
          raw = ZONE_GAIN_UP;
        end
        else
        begin
          raw = ZONE_LOW_FLOOR;
        end
        // RQ12: restore high gain
        if (avg < s_q.gain_restore_trip)
        begin
          s_d.gain = ALZ_GAIN_HIGH;
          raw = s_q.zone;
        end
      end
      else if (autogain && raw > ZONE_GAIN_UP)
      begin
        // RQ15: cap before gain change
        raw = ZONE_GAIN_UP;
      end

      // RQ6: two agreeing periods
      s_d.cand = raw;
      if (raw == s_q.cand && raw != s_q.zone)
      begin
        s_d.zone = raw;
        // RQ7: flag zone change
        s_d.irq_pending = 1'b1;
        // RQ11: zone three selects low gain
        if (autogain && s_q.autogain_prev && s_q.gain == ALZ_GAIN_HIGH && raw == ZONE_GAIN_UP)
        begin
          s_d.gain = ALZ_GAIN_LOW;
          s_d.cand = raw;
        end
      end
    end

    // RQ3: stepwise ramp pacing
    if (enabled)
    begin
      if (s_q.ramp_cnt == RAMP_CNT_W'(RAMP_CYCLES - 1))
      begin
        s_d.ramp_cnt = '0;
        s_d.ramp_step = 1'b1;
      end
      else
      begin
        s_d.ramp_cnt = s_q.ramp_cnt + RAMP_CNT_W'(1);
      end
    end

    // RQ10: gain shown on outputs
    if (autogain)
    begin
      s_d.out_one = (s_d.gain == ALZ_GAIN_HIGH);
      s_d.out_two = (s_d.gain == ALZ_GAIN_LOW);
    end
    else
    begin
      s_d.out_one = s_d.gpo_ctrl[GPO_ONE_BIT];
      s_d.out_two = s_d.gpo_ctrl[GPO_TWO_BIT];
    end

    // RQ8: code zero leaves input open
    s_d.load_open = (s_d.load_res == '0);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.gpo_ctrl <= RST_GPO;
      s_q.config_reg <= RST_CONFIG;
      s_q.load_res <= RST_LOAD_RES;
      s_q.bound <= {NUM_BOUND{RST_BOUND}};
      s_q.target <= {NUM_ZONE{RST_TARGET}};
      s_q.gain_restore_trip <= RST_TRIP;
      s_q.low_gain_descent_boundary <= RST_DESCENT;
      s_q.gain <= ALZ_GAIN_HIGH;
      s_q.load_open <= 1'b1;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // RQ3: ramp toward zone target
  assign rif.target = s_q.target[s_q.zone];
  assign rif.step = s_q.ramp_step;

  alz_ramp u_ramp (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .rp(rif.ramp)
  );

  assign reg_rdata = s_q.rdata;
  assign adc_start = s_q.adc_start;
  assign load_select = s_q.load_res;
  assign load_open = s_q.load_open;
  assign general_output_one = s_q.out_one;
  assign general_output_two = s_q.out_two;
  // The pin only ever sinks; the pull-up supplies the high level.
  assign irq_n_out = 1'b0;
  assign irq_n_oe = s_q.irq_pending;
  assign led_level = rif.level;
endmodule
`default_nettype wire

// ===== tb/alz_engine_chk.sv
// Port-level assertion checker for the ambient light zone engine.
`timescale 1ns/1ps
`default_nettype none
module alz_engine_chk
  import alz_pkg::*;
#(
  parameter int unsigned RAMP_CYCLES = 4
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic adc_start,
  input wire logic adc_valid,
  input wire logic [LEVEL_W-1:0] adc_data,
  input wire logic [LOAD_W-1:0] load_select,
  input wire logic load_open,
  input wire logic general_output_one,
  input wire logic general_output_two,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic [BRIGHT_W-1:0] led_level
);
  logic ag_q;
  logic seen_q;
  logic [15:0] st_cnt_q;
  logic [15:0] lv_cnt_q;
  logic [BRIGHT_W-1:0] led_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Shadows of the auto-gain bit and spacing counters for converter starts and ramp steps.
  // Starts are counted in enabled cycles only, since a frozen engine stretches their gap.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ag_q <= 1'b0;
      seen_q <= 1'b0;
      st_cnt_q <= 16'h0000;
      lv_cnt_q <= 16'hffff;
      led_q <= '0;
    end
    else
    begin
      if (clk_en)
      begin
        if (reg_wr && reg_addr == ADDR_CONFIG)
        begin
          ag_q <= reg_wdata[CFG_AUTOGAIN_BIT];
        end
        seen_q <= seen_q | adc_start;
        st_cnt_q <= adc_start ? 16'h0000 : st_cnt_q + 16'h0001;
      end
      led_q <= led_level;
      if (led_level != led_q)
        lv_cnt_q <= 16'h0000;
      else if (lv_cnt_q != 16'hffff)
        lv_cnt_q <= lv_cnt_q + 16'h0001;
    end
  end
  property p_load_open;
    load_open == (load_select == 5'h00);
  endproperty
  a_load_open: assert property (p_load_open) else $error("load open flag wrong");
  property p_load_wr;
    reg_wr && clk_en && reg_addr == ADDR_LOAD_RES |-> ##2 load_select == $past(reg_wdata[4:0], 2);
  endproperty
  a_load_wr: assert property (p_load_wr) else $error("load select not updated");
  property p_gpo_wr;
    reg_wr && clk_en && reg_addr == ADDR_GPO_CTRL && !ag_q |-> ##2
      general_output_one == $past(reg_wdata[0], 2) && general_output_two == $past(reg_wdata[1], 2);
  endproperty
  a_gpo_wr: assert property (p_gpo_wr) else $error("general outputs ignore bits");
  property p_gpo_ag;
    ag_q && $past(ag_q, 2) |-> general_output_one != general_output_two;
  endproperty
  a_gpo_ag: assert property (p_gpo_ag) else $error("gain pins not opposite");
  property p_adc_gap;
    adc_start && seen_q && clk_en |-> st_cnt_q == 16'(SAMPLE_CYCLES - 1);
  endproperty
  a_adc_gap: assert property (p_adc_gap) else $error("converter start spacing wrong");
  property p_ramp_step;
    $changed(led_level) |-> led_level == $past(led_level) + 7'h01 ||
      led_level == $past(led_level) - 7'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("brightness jumped");
  property p_ramp_gap;
    led_level != led_q |-> lv_cnt_q >= 16'(RAMP_CYCLES - 1);
  endproperty
  a_ramp_gap: assert property (p_ramp_gap) else $error("brightness steps too close");
  property p_irq_low;
    irq_n_out == 1'b0;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt pin drives high");
  property p_irq_hold;
    irq_n_oe && !(reg_rd && clk_en && reg_addr == ADDR_STATUS) |=> irq_n_oe;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unread");
  property p_freeze;
    !clk_en |=> $stable(led_level) && $stable(irq_n_oe) && $stable(reg_rdata) &&
      $stable(general_output_one) && $stable(general_output_two) && $stable(load_select) &&
      $stable(adc_start);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved with clock enable low");
endmodule
bind alz_engine alz_engine_chk #(.RAMP_CYCLES(RAMP_CYCLES)) alz_engine_chk_i (.clock, .arst_n,
  .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .adc_start, .adc_valid,
  .adc_data, .load_select, .load_open, .general_output_one, .general_output_two, .irq_n_out,
  .irq_n_oe, .led_level);
`default_nettype wire

// ===== tb/alz_sensor_model.sv
// Light sensor with hardware gain pins and a fast converter.
`timescale 1ns/1ps
`default_nettype none
module alz_sensor_model
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] lux,
  input wire logic gain_one,
  input wire logic gain_two,
  output var logic adc_valid,
  output var logic [7:0] adc_data
);
  wire logic low_gain = !gain_one && gain_two;
  // Between samples the data lines carry junk, so a stale value is never taken for a result.
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      adc_valid <= 1'b0;
      adc_data <= 8'h00;
    end
    else
    begin
      adc_valid <= !adc_valid;
      adc_data <= adc_valid ? ~adc_data : (low_gain ? lux >> 2 : lux);
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_alz_engine.sv
// Self-checking bench for the ambient light zone engine.
`timescale 1ns/1ps
`default_nettype none
module tb_alz_engine import alz_pkg::*;;
  localparam int B1 = 3 * 1024 + 64;
  localparam int B2 = 6 * 1024 + 64;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] lux = 8'h10;
  logic clk_en = 1'b1;
  logic [7:0] reg_rdata, adc_data, st;
  logic adc_start, adc_valid, load_open, gpo_one, gpo_two, irq_n_out, irq_n_oe;
  logic [4:0] load_select;
  logic [6:0] led_level;
  logic [4:0] lcodes [3] = '{5'h1f, 5'h01, 5'h00};
  int miscompares = 0;
  int n_tests = 0;
  always #20 clock = ~clock;
  alz_engine #(.RAMP_CYCLES(4)) alz_engine_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_valid(adc_valid), .adc_data(adc_data),
    .load_select(load_select), .load_open(load_open), .general_output_one(gpo_one),
    .general_output_two(gpo_two), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .led_level(led_level));
  alz_sensor_model alz_sensor_model_i (.clock(clock), .arst_n(arst_n), .lux(lux),
    .gain_one(gpo_one), .gain_two(gpo_two), .adc_valid(adc_valid), .adc_data(adc_data));
  function automatic logic [7:0] tgt(input int z);
    return 8'(z * 16 + 3);
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask
  // Waits for the zone change, checks the zone, the interrupt clear and the final brightness.
  task automatic zone_step(input logic [7:0] l, input int z, input int bound);
    int i;
    @(posedge clock);
    lux <= l;
    i = 0;
    while (irq_n_oe !== 1'b1 && i < bound)
    begin
      @(posedge clock);
      #1 i++;
    end
    chk(8'(irq_n_oe), 8'h01);
    // Two agreeing period ends cannot come sooner than one full averaging period.
    chk(8'(i > bound / 4), 8'h01);
    rd(ADDR_STATUS);
    chk(8'(st[2:0]), 8'(z));
    chk(8'(irq_n_oe), 8'h00);
    i = 0;
    while ({1'b0, led_level} !== tgt(z) && i < 600)
    begin
      @(posedge clock);
      #1 i++;
    end
    chk({1'b0, led_level}, tgt(z));
  endtask
  initial
  begin
    repeat (90000) @(posedge clock);
    miscompares++;
    final_report;
  end
  initial
  begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    rd(ADDR_GPO_CTRL);
    chk(st, RST_GPO);
    for (int a = 8'h60; a <= 8'h6e; a++)
    begin
      rd(8'(a));
      chk(st, 8'h00);
    end
    wr(8'h70, 8'ha5);
    rd(8'h70);
    chk(st, 8'h00);
    for (int v = 0; v < 4; v++)
    begin
      wr(ADDR_GPO_CTRL, 8'(v));
      rd(ADDR_GPO_CTRL);
      chk(st, 8'(v));
      chk(8'({gpo_two, gpo_one}), 8'(v));
    end
    // A write offered while the clock enable is low must be lost.
    @(posedge clock);
    clk_en <= 1'b0;
    wr(ADDR_GPO_CTRL, 8'h00);
    @(posedge clock);
    chk(8'({gpo_two, gpo_one}), 8'h03);
    clk_en <= 1'b1;
    rd(ADDR_GPO_CTRL);
    chk(st, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_LOAD_RES, {3'h7, lcodes[k]});
      rd(ADDR_LOAD_RES);
      chk(st, {3'h0, lcodes[k]});
      chk(8'(load_open), 8'(lcodes[k] == 5'h00));
    end
    for (int z = 0; z < 5; z++)
    begin
      if (z < 4)
        wr(ADDR_BOUND0 + 8'(z), 8'(32 * (z + 1)));
      wr(ADDR_TARGET0 + 8'(z), 8'h80 | tgt(z));
    end
    rd(ADDR_TARGET0 + 8'h04);
    chk(st, tgt(4));
    wr(ADDR_TRIP, 8'h10);
    wr(ADDR_DESCENT, 8'h18);
    wr(ADDR_CONFIG, 8'h01);
    zone_step(8'h30, 1, B1);
    zone_step(8'h60, 2, B1);
    zone_step(8'h90, 4, B1);
    zone_step(8'h10, 0, B1);
    wr(ADDR_CONFIG, 8'h05);
    zone_step(8'h70, 3, B2);
    zone_step(8'h10, 0, B2);
    wr(ADDR_CONFIG, 8'h07);
    rd(ADDR_STATUS);
    chk(8'(st[3]), 8'h00);
    chk(8'({gpo_two, gpo_one}), 8'h01);
    zone_step(8'hff, 3, B2);
    chk(8'(st[3]), 8'h01);
    chk(8'({gpo_two, gpo_one}), 8'h02);
    zone_step(8'h50, 2, B2);
    chk(8'(st[3]), 8'h01);
    zone_step(8'h28, 1, 8 * 1024 + 64);
    chk(8'(st[3]), 8'h00);
    chk(8'({gpo_two, gpo_one}), 8'h01);
    final_report;
  end
endmodule
`default_nettype wire
